// *** rtl/pchbp_pkg.sv ***
// Constants for the host-side controller of the strobe-per-lane memory port.
// Assumes a 32-bit APB slave at 250 MHz and a device sitting behind the pins.
package pchbp_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] PCHBP_OFS_CTRL   = 8'h00;
    localparam logic [7:0] PCHBP_OFS_ADDR   = 8'h04;
    localparam logic [7:0] PCHBP_OFS_WDATA  = 8'h08;
    localparam logic [7:0] PCHBP_OFS_RDATA  = 8'h0c;
    localparam logic [7:0] PCHBP_OFS_STATUS = 8'h10;
    localparam logic [7:0] PCHBP_OFS_STRAP  = 8'h14;
    // Control register fields
    localparam int PCHBP_CTRL_GO    = 0;
    localparam int PCHBP_CTRL_WRITE = 1;
    localparam int PCHBP_CTRL_LANE0 = 2;
    localparam int PCHBP_CTRL_LANE1 = 3;
    localparam int PCHBP_CTRL_RESET = 4;
    // Status register fields
    localparam int PCHBP_ST_BUSY    = 0;
    localparam int PCHBP_ST_DONE    = 1;
    localparam int PCHBP_ST_WAITSEEN = 2;
    // Strap pattern: bit3 reserved one, bits 4,2,1,0 = 0 1 0 0
    localparam logic [6:0] PCHBP_STRAP_RESET = 7'h0c;
    localparam logic [6:0] PCHBP_STRAP_FIXED_MASK = 7'h1f;
    // Timing, in ns, and derived cycle counts
    localparam int PCHBP_CLK_NS       = 4;
    localparam int PCHBP_SETUP_NS     = 20;
    localparam int PCHBP_SETUP_CYC    = (PCHBP_SETUP_NS + PCHBP_CLK_NS - 1) / PCHBP_CLK_NS;
    localparam int PCHBP_WAITLAT_NS   = 40;
    localparam int PCHBP_WAITLAT_CYC  = (PCHBP_WAITLAT_NS + PCHBP_CLK_NS - 1) / PCHBP_CLK_NS;
    localparam int PCHBP_RECOVER_NS   = 20;
    localparam int PCHBP_RECOVER_CYC  = (PCHBP_RECOVER_NS + PCHBP_CLK_NS - 1) / PCHBP_CLK_NS;
    localparam int PCHBP_RSTHOLD_NS   = 400;
    localparam int PCHBP_RSTHOLD_CYC  = (PCHBP_RSTHOLD_NS + PCHBP_CLK_NS - 1) / PCHBP_CLK_NS;
    // Cycle state machine
    typedef enum logic [4:0] {
        PCHBP_IDLE   = 5'b00001,
        PCHBP_SETUP  = 5'b00010,
        PCHBP_STROBE = 5'b00100,
        PCHBP_WAITHI = 5'b01000,
        PCHBP_RECOV  = 5'b10000
    } pchbp_state_t;
endpackage

// *** rtl/pchbp_host.sv ***
// Host-side controller that runs memory cycles on the strobe-per-lane port.
// Assumes an APB master on CLK; device pins are asynchronous to CLK.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Bits 4,2,1,0 driven as 0 1 0 0
// - Reserved strap bit 3 held at one
// - Select driven from address bit 18
// - Only address bits 18..0 are meaningful
// - Chip select driven low from setup through wait, from cycle state
// - High strobe with bit 0 steers bytes
// - Write strobe low for whole write
// - Read strobe low for whole read
// - Host extends cycle while wait asserted
// - Bus start and direction tied high
// - Device reset driven active low
// - Free-running input clock supplied
// - Enables select word, even or odd byte
// - Cycle spans enable assertion to release
module pchbp_host #(
    parameter int ADDR_W = 19
) (
    // Clock, reset, enable
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Device address and select
    output logic [17:0]      HOST_ADDRESS_IN,
    output logic             MEM_REG_SEL,
    output logic             CHIP_SELECT_N,
    // Device strobes
    output logic             HIGH_BYTE_STROBE_N,
    output logic             LOW_BYTE_WRITE_STROBE_N,
    output logic             READ_STROBE_N,
    output logic             BUS_START_N,
    output logic             READ_WRITE_N,
    // Device data bus, split three ways
    input  wire logic [15:0] HOST_DATA_BUS_I,
    output logic      [15:0] HOST_DATA_BUS_O,
    output logic             HOST_DATA_BUS_OE,
    // Device wait and reset
    input  wire logic        WAIT_IN,
    output logic             DEVICE_RESET_N,
    // Configuration straps
    output logic [6:0]       STRAP_OUT,
    // Free-running device clock
    output logic             INPUT_CLOCK
);
    // Parameter check
    if (ADDR_W != 19) begin : g_bad_addr
        $error("ADDR_W must be 19");
    end

    // Registers
    pchbp_pkg::pchbp_state_t st_r, st_nxt;
    logic [18:0] addr_r, addr_nxt;
    logic [15:0] wdata_r, wdata_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic        wr_r, wr_nxt;
    logic [1:0]  lane_r, lane_nxt;
    logic        done_r, done_nxt;
    logic        wseen_r, wseen_nxt;
    logic [6:0]  strap_r, strap_nxt;
    logic        rst_r, rst_nxt;
    logic [7:0]  cnt_r, cnt_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic        clkdiv_r, clkdiv_nxt;
    logic        wait_s1_r, wait_s2_r;
    logic [15:0] data_s1_r, data_s2_r;

    // Wait polarity follows the strap being driven
    function automatic logic wait_active(input logic lvl, input logic pol);
        return pol ? lvl : ~lvl;
    endfunction

    logic apb_setup;
    logic apb_access;
    logic wait_on;
    assign apb_setup = PSEL && !PENABLE;
    assign apb_access = PSEL && PENABLE && pready_r;
    assign wait_on = wait_active(wait_s2_r, strap_r[5]);

    // Next-state logic
    always_comb begin
        st_nxt      = st_r;
        addr_nxt    = addr_r;
        wdata_nxt   = wdata_r;
        rdata_nxt   = rdata_r;
        wr_nxt      = wr_r;
        lane_nxt    = lane_r;
        done_nxt    = done_r;
        wseen_nxt   = wseen_r;
        strap_nxt   = strap_r;
        rst_nxt     = rst_r;
        cnt_nxt     = cnt_r;
        prdata_nxt  = prdata_r;
        pready_nxt  = 1'b0;
        pslverr_nxt = 1'b0;
        clkdiv_nxt  = ~clkdiv_r;
        // Device reset hold, then release to latch straps
        if (!rst_r) begin
            if (cnt_r == 8'(pchbp_pkg::PCHBP_RSTHOLD_CYC)) begin
                rst_nxt = 1'b1;
                cnt_nxt = 8'h00;
            end else begin
                cnt_nxt = cnt_r + 8'h01;
            end
        end
        // APB read data prepared in the setup cycle, one wait-free access cycle
        if (apb_setup) begin
            pready_nxt = 1'b1;
            case (PADDR)
                pchbp_pkg::PCHBP_OFS_CTRL:   prdata_nxt = {31'h0, st_r != pchbp_pkg::PCHBP_IDLE};
                pchbp_pkg::PCHBP_OFS_ADDR:   prdata_nxt = {13'h0, addr_r};
                pchbp_pkg::PCHBP_OFS_WDATA:  prdata_nxt = {16'h0, wdata_r};
                pchbp_pkg::PCHBP_OFS_RDATA:  prdata_nxt = {16'h0, rdata_r};
                pchbp_pkg::PCHBP_OFS_STATUS: prdata_nxt = {29'h0, wseen_r, done_r, st_r != pchbp_pkg::PCHBP_IDLE};
                pchbp_pkg::PCHBP_OFS_STRAP:  prdata_nxt = {25'h0, strap_r};
                default: begin
                    prdata_nxt = 32'h0;
                    pslverr_nxt = 1'b1;
                end
            endcase
        end
        // Writes land at the access edge; cycle settings frozen while a cycle runs
        if (apb_access && PWRITE) begin
            case (PADDR)
                pchbp_pkg::PCHBP_OFS_CTRL: begin
                    if (st_r == pchbp_pkg::PCHBP_IDLE) begin
                        lane_nxt = {PWDATA[pchbp_pkg::PCHBP_CTRL_LANE1], PWDATA[pchbp_pkg::PCHBP_CTRL_LANE0]};
                        wr_nxt = PWDATA[pchbp_pkg::PCHBP_CTRL_WRITE];
                        if (PWDATA[pchbp_pkg::PCHBP_CTRL_RESET]) begin
                            rst_nxt = 1'b0;
                            cnt_nxt = 8'h00;
                        end else if (PWDATA[pchbp_pkg::PCHBP_CTRL_GO] && rst_r
                                     && PWDATA[pchbp_pkg::PCHBP_CTRL_LANE1:pchbp_pkg::PCHBP_CTRL_LANE0] != 2'b00) begin
                            st_nxt = pchbp_pkg::PCHBP_SETUP;
                            cnt_nxt = 8'h00;
                            done_nxt = 1'b0;
                            wseen_nxt = 1'b0;
                        end
                    end
                end
                pchbp_pkg::PCHBP_OFS_ADDR: begin
                    if (st_r == pchbp_pkg::PCHBP_IDLE) addr_nxt = PWDATA[18:0];
                end
                pchbp_pkg::PCHBP_OFS_WDATA: begin
                    if (st_r == pchbp_pkg::PCHBP_IDLE) wdata_nxt = PWDATA[15:0];
                end
                pchbp_pkg::PCHBP_OFS_STRAP: begin
                    if (!rst_r) begin
                        // Only polarity and divide are free; bus select fixed
                        strap_nxt = (PWDATA[6:0] & ~pchbp_pkg::PCHBP_STRAP_FIXED_MASK)
                                    | pchbp_pkg::PCHBP_STRAP_RESET;
                    end
                end
                default: begin
                end
            endcase
        end
        // Device cycle sequencer
        case (st_r)
            pchbp_pkg::PCHBP_IDLE: begin
            end
            pchbp_pkg::PCHBP_SETUP: begin
                if (cnt_r == 8'(pchbp_pkg::PCHBP_SETUP_CYC)) begin
                    st_nxt = pchbp_pkg::PCHBP_STROBE;
                    cnt_nxt = 8'h00;
                end else begin
                    cnt_nxt = cnt_r + 8'h01;
                end
            end
            pchbp_pkg::PCHBP_STROBE: begin
                // Give the device time to sync and raise wait
                if (wait_on) begin
                    wseen_nxt = 1'b1;
                    st_nxt = pchbp_pkg::PCHBP_WAITHI;
                end else if (cnt_r == 8'(pchbp_pkg::PCHBP_WAITLAT_CYC)) begin
                    st_nxt = pchbp_pkg::PCHBP_WAITHI;
                end else begin
                    cnt_nxt = cnt_r + 8'h01;
                end
            end
            pchbp_pkg::PCHBP_WAITHI: begin
                if (!wait_on) begin
                    if (!wr_r) rdata_nxt = data_s2_r;
                    st_nxt = pchbp_pkg::PCHBP_RECOV;
                    cnt_nxt = 8'h00;
                end
            end
            pchbp_pkg::PCHBP_RECOV: begin
                if (cnt_r == 8'(pchbp_pkg::PCHBP_RECOVER_CYC)) begin
                    st_nxt = pchbp_pkg::PCHBP_IDLE;
                    done_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + 8'h01;
                end
            end
            default: st_nxt = pchbp_pkg::PCHBP_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_r      <= pchbp_pkg::PCHBP_IDLE;
            addr_r    <= 19'h0;
            wdata_r   <= 16'h0;
            rdata_r   <= 16'h0;
            wr_r      <= 1'b0;
            lane_r    <= 2'b00;
            done_r    <= 1'b0;
            wseen_r   <= 1'b0;
            strap_r   <= pchbp_pkg::PCHBP_STRAP_RESET;
            rst_r     <= 1'b0;
            cnt_r     <= 8'h00;
            prdata_r  <= 32'h0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            clkdiv_r  <= 1'b0;
            wait_s1_r <= 1'b0;
            wait_s2_r <= 1'b0;
            data_s1_r <= 16'h0;
            data_s2_r <= 16'h0;
        end else if (CE) begin
            st_r      <= st_nxt;
            addr_r    <= addr_nxt;
            wdata_r   <= wdata_nxt;
            rdata_r   <= rdata_nxt;
            wr_r      <= wr_nxt;
            lane_r    <= lane_nxt;
            done_r    <= done_nxt;
            wseen_r   <= wseen_nxt;
            strap_r   <= strap_nxt;
            rst_r     <= rst_nxt;
            cnt_r     <= cnt_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            clkdiv_r  <= clkdiv_nxt;
            wait_s1_r <= WAIT_IN;
            wait_s2_r <= wait_s1_r;
            // Read data synchronised alongside wait so both are seen together
            data_s1_r <= HOST_DATA_BUS_I;
            data_s2_r <= data_s1_r;
        end
    end

    // Pin registers
    logic cyc_act;
    logic strobe_act;
    assign cyc_act = st_nxt != pchbp_pkg::PCHBP_IDLE && st_nxt != pchbp_pkg::PCHBP_RECOV;
    assign strobe_act = st_nxt == pchbp_pkg::PCHBP_STROBE || st_nxt == pchbp_pkg::PCHBP_WAITHI;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            HOST_ADDRESS_IN         <= 18'h0;
            MEM_REG_SEL             <= 1'b0;
            CHIP_SELECT_N           <= 1'b1;
            HIGH_BYTE_STROBE_N      <= 1'b1;
            LOW_BYTE_WRITE_STROBE_N <= 1'b1;
            READ_STROBE_N           <= 1'b1;
            BUS_START_N             <= 1'b1;
            READ_WRITE_N            <= 1'b1;
            HOST_DATA_BUS_O         <= 16'h0;
            HOST_DATA_BUS_OE        <= 1'b0;
            DEVICE_RESET_N          <= 1'b0;
            STRAP_OUT               <= pchbp_pkg::PCHBP_STRAP_RESET;
            INPUT_CLOCK             <= 1'b0;
        end else if (CE) begin
            HOST_ADDRESS_IN         <= addr_nxt[17:0];
            MEM_REG_SEL             <= addr_nxt[18];
            CHIP_SELECT_N           <= ~cyc_act;
            // Upper enable for word or odd byte; lower via bit 0
            HIGH_BYTE_STROBE_N      <= ~(strobe_act && lane_nxt[1]);
            LOW_BYTE_WRITE_STROBE_N <= ~(strobe_act && wr_nxt);
            READ_STROBE_N           <= ~(strobe_act && !wr_nxt);
            BUS_START_N             <= 1'b1;
            READ_WRITE_N            <= 1'b1;
            HOST_DATA_BUS_O         <= wdata_nxt;
            HOST_DATA_BUS_OE        <= cyc_act && wr_nxt;
            DEVICE_RESET_N          <= rst_nxt;
            STRAP_OUT               <= strap_nxt;
            INPUT_CLOCK             <= clkdiv_nxt;
        end
    end

    assign PRDATA  = prdata_r;
    assign PREADY  = pready_r;
    assign PSLVERR = pslverr_r;
endmodule
`default_nettype wire

// *** testbench/pchbp_host_chk.sv ***
// Concurrent checks on the device-pin side of the host port controller.
// Bound to pchbp_host; sees only its ports, one clock, async active-low reset.
`timescale 1ns/100ps
`default_nettype none
module pchbp_host_chk (
    // Clock and reset
    input wire logic        CLK, RST_N, CE,
    // Device strobes, select and data enable
    input wire logic        CHIP_SELECT_N, LOW_BYTE_WRITE_STROBE_N, READ_STROBE_N,
    input wire logic        BUS_START_N, READ_WRITE_N, MEM_REG_SEL, HOST_DATA_BUS_OE,
    // Wait, device reset, device clock
    input wire logic        WAIT_IN, DEVICE_RESET_N, INPUT_CLOCK,
    // Address and straps
    input wire logic [17:0] HOST_ADDRESS_IN,
    input wire logic [6:0]  STRAP_OUT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Read or write strobe active
    wire logic strb = !READ_STROBE_N || !LOW_BYTE_WRITE_STROBE_N;
    // Steps of a device cycle: quiet setup, then wait held at its active level
    sequence s_setup; !strb [*5]; endsequence
    sequence s_wait; (WAIT_IN == STRAP_OUT[5]) [*4]; endsequence
    a_strap_fixed: assert property (STRAP_OUT[4:0] == 5'h0c)
        else $error("fixed strap bits wrong");
    a_pins_tied: assert property (BUS_START_N && READ_WRITE_N)
        else $error("unused inputs not held high");
    a_quiet_reset: assert property (!DEVICE_RESET_N |-> CHIP_SELECT_N)
        else $error("cycle while device held in reset");
    a_dir_excl: assert property (!(!READ_STROBE_N && !LOW_BYTE_WRITE_STROBE_N))
        else $error("read and write strobes together");
    a_write_drive: assert property (!LOW_BYTE_WRITE_STROBE_N |-> HOST_DATA_BUS_OE)
        else $error("write strobe without data driven");
    a_read_float: assert property (!READ_STROBE_N |-> !HOST_DATA_BUS_OE)
        else $error("data driven during read");
    a_strobe_cs: assert property (strb |-> !CHIP_SELECT_N)
        else $error("strobe outside chip select");
    a_cs_setup: assert property ($fell(CHIP_SELECT_N) |-> s_setup)
        else $error("strobe too soon after select");
    a_addr_hold: assert property (!CHIP_SELECT_N && $past(!CHIP_SELECT_N) |->
        $stable(HOST_ADDRESS_IN) && $stable(MEM_REG_SEL)) else $error("address moved in cycle");
    a_wait_stretch: assert property (s_wait ##0 strb |=> strb)
        else $error("strobe ended while wait active");
    a_clock_runs: assert property (CE |=> INPUT_CLOCK != $past(INPUT_CLOCK))
        else $error("device clock stopped");
endmodule
bind pchbp_host pchbp_host_chk u_chk (.CLK(CLK), .RST_N(RST_N), .CE(CE), .CHIP_SELECT_N(CHIP_SELECT_N),
    .LOW_BYTE_WRITE_STROBE_N(LOW_BYTE_WRITE_STROBE_N), .READ_STROBE_N(READ_STROBE_N),
    .BUS_START_N(BUS_START_N), .READ_WRITE_N(READ_WRITE_N), .MEM_REG_SEL(MEM_REG_SEL),
    .HOST_DATA_BUS_OE(HOST_DATA_BUS_OE), .WAIT_IN(WAIT_IN), .DEVICE_RESET_N(DEVICE_RESET_N),
    .INPUT_CLOCK(INPUT_CLOCK), .HOST_ADDRESS_IN(HOST_ADDRESS_IN), .STRAP_OUT(STRAP_OUT));
`default_nettype wire

// *** testbench/pchbp_dev_model.sv ***
// Behavioural model of the documented device behind the strobe-per-lane port.
// Assumes the bench resolves the data bus; slow selects long arbitration waits.
`timescale 1ns/100ps
`default_nettype none
module pchbp_dev_model (
    // Clock, device reset, wait length select
    input  wire logic        clk, dev_rst_n, slow,
    // Select and strobes
    input  wire logic        cs_n, rd_n, wr_n, hi_n, sel, oe,
    input  wire logic [17:0] addr,
    input  wire logic [6:0]  strap,
    // Data and wait
    input  wire logic [15:0] din,
    output logic      [15:0] dout,
    output logic             wait_out
);
    logic [6:0]  straps = 7'h00;
    logic [15:0] last = 16'h0000;
    logic [15:0] mem [262144];
    int          cnt = 0;
    // Only bits 18..0 decode: select picks the block, bit 0 the byte
    wire logic [17:0] key = {sel, addr[17:1]};
    wire logic [15:0] w = mem[key];
    wire logic act = !cs_n && (!rd_n || !wr_n);
    wire logic busy = act && cnt < (slow ? 24 : 2);
    // Straps latched as reset releases
    always @(posedge dev_rst_n) straps <= strap;
    // Wait at the strapped polarity while arbitration runs
    assign wait_out = busy ? straps[5] : ~straps[5];
    // Arbitration count, bus history and steered writes
    always @(posedge clk) begin
        cnt <= act ? cnt + 1 : 0;
        last <= dout;
        if (act && !wr_n && oe && !busy)
            mem[key] <= hi_n ? (addr[0] ? {din[7:0], w[7:0]} : {w[15:8], din[7:0]})
                             : (addr[0] ? {din[15:8], w[7:0]} : din);
    end
    // Read data only once ready; otherwise a changing pattern
    always_comb begin
        dout = ~last;
        if (!cs_n && !rd_n && !busy)
            dout = hi_n ? {~last[15:8], addr[0] ? w[15:8] : w[7:0]} : (addr[0] ? {w[15:8], ~last[7:0]} : w);
    end
endmodule
`default_nettype wire

// *** testbench/pc_card_host_bus_port_test.sv ***
// Self-checking bench for the host port controller, APB master plus device model.
// Assumes pchbp_host and pchbp_dev_model; clock 250 MHz, reset held two cycles.
`timescale 1ns/100ps
`default_nettype none
module pc_card_host_bus_port_test;
    typedef struct packed {logic w; logic [1:0] ln; logic [18:0] a; logic [15:0] d; logic [15:0] m;} pchbp_row_t;
    logic CLK, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, slow = 1'b0, er, CE = 1'b1, ck;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, rd;
    wire logic [31:0] PRDATA;
    wire logic PREADY, PSLVERR, MEM_REG_SEL, CHIP_SELECT_N, HIGH_BYTE_STROBE_N, LOW_BYTE_WRITE_STROBE_N;
    wire logic READ_STROBE_N, BUS_START_N, READ_WRITE_N, HOST_DATA_BUS_OE, WAIT_IN, DEVICE_RESET_N, INPUT_CLOCK;
    wire logic [17:0] HOST_ADDRESS_IN;
    wire logic [15:0] HOST_DATA_BUS_I, HOST_DATA_BUS_O;
    wire logic [6:0] STRAP_OUT;
    int mismatches = 0, tests_run = 0, cyc = 0;
    // Word traffic in both blocks, byte and upper-lane traffic in the select-high block; reads carry expected data and mask
    pchbp_row_t rows [10] = '{'{1, 3, 19'h00010, 16'ha5c3, 16'hffff}, '{0, 3, 19'h00010, 16'ha5c3, 16'hffff},
        '{1, 3, 19'h40010, 16'h1234, 16'hffff}, '{0, 3, 19'h00010, 16'ha5c3, 16'hffff},
        '{0, 3, 19'h40010, 16'h1234, 16'hffff}, '{1, 1, 19'h40011, 16'h0077, 16'hffff},
        '{0, 3, 19'h40010, 16'h7734, 16'hffff}, '{0, 1, 19'h40011, 16'h0077, 16'h00ff},
        '{1, 2, 19'h40011, 16'h9900, 16'hffff}, '{0, 3, 19'h40010, 16'h9934, 16'hffff}};
    pchbp_host DUT (.CLK(CLK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .HOST_ADDRESS_IN(HOST_ADDRESS_IN), .MEM_REG_SEL(MEM_REG_SEL), .CHIP_SELECT_N(CHIP_SELECT_N),
        .HIGH_BYTE_STROBE_N(HIGH_BYTE_STROBE_N), .LOW_BYTE_WRITE_STROBE_N(LOW_BYTE_WRITE_STROBE_N),
        .READ_STROBE_N(READ_STROBE_N), .BUS_START_N(BUS_START_N), .READ_WRITE_N(READ_WRITE_N),
        .HOST_DATA_BUS_I(HOST_DATA_BUS_I), .HOST_DATA_BUS_O(HOST_DATA_BUS_O), .HOST_DATA_BUS_OE(HOST_DATA_BUS_OE),
        .WAIT_IN(WAIT_IN), .DEVICE_RESET_N(DEVICE_RESET_N), .STRAP_OUT(STRAP_OUT), .INPUT_CLOCK(INPUT_CLOCK));
    pchbp_dev_model u_dev (.clk(INPUT_CLOCK), .dev_rst_n(DEVICE_RESET_N), .slow(slow), .cs_n(CHIP_SELECT_N),
        .rd_n(READ_STROBE_N), .wr_n(LOW_BYTE_WRITE_STROBE_N), .hi_n(HIGH_BYTE_STROBE_N), .sel(MEM_REG_SEL),
        .oe(HOST_DATA_BUS_OE), .addr(HOST_ADDRESS_IN), .strap(STRAP_OUT), .din(HOST_DATA_BUS_O),
        .dout(HOST_DATA_BUS_I), .wait_out(WAIT_IN));
    // Clock
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    // Cycle ceiling against hangs
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            wrap_up;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // One APB transfer; waits for pready, keeps read data and error flag
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK);
        while (PREADY !== 1'b1) @(posedge CLK);
        rd = PRDATA;
        er = PSLVERR;
        {PSEL, PENABLE} <= 2'b00;
    endtask
    // One device cycle: address, data, go, poll done, fetch read data
    task run(input pchbp_row_t r);
        apb(1'b1, pchbp_pkg::PCHBP_OFS_ADDR, {13'h0, r.a});
        apb(1'b1, pchbp_pkg::PCHBP_OFS_WDATA, {16'h0, r.d});
        apb(1'b1, pchbp_pkg::PCHBP_OFS_CTRL, {28'h0, r.ln, r.w, 1'b1});
        for (int i = 0; i < 200; i++) begin
            apb(1'b0, pchbp_pkg::PCHBP_OFS_STATUS, 32'h0);
            if (rd[1] === 1'b1) break;
        end
        apb(1'b0, pchbp_pkg::PCHBP_OFS_RDATA, 32'h0);
    endtask
    task settle;
        for (int i = 0; i < 300 && DEVICE_RESET_N !== 1'b1; i++) @(posedge CLK);
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        chk({31'h0, DEVICE_RESET_N}, 32'h0);
        apb(1'b1, pchbp_pkg::PCHBP_OFS_STRAP, 32'h60);
        apb(1'b0, pchbp_pkg::PCHBP_OFS_STRAP, 32'h0);
        chk(rd, 32'h6c);
        settle;
        chk({25'h0, u_dev.straps}, 32'h6c);
        foreach (rows[i]) begin
            run(rows[i]);
            if (!rows[i].w) chk(rd & {16'h0, rows[i].m}, {16'h0, rows[i].d & rows[i].m});
        end
        // Long arbitration waits on write and read
        slow <= 1'b1;
        run('{1'b1, 2'b11, 19'h40020, 16'hbeef, 16'hffff});
        run('{1'b0, 2'b11, 19'h40020, 16'h0, 16'hffff});
        chk(rd, 32'hbeef);
        apb(1'b0, pchbp_pkg::PCHBP_OFS_STATUS, 32'h0);
        chk({31'h0, rd[2]}, 32'h1);
        apb(1'b1, 8'h18, 32'h0);
        chk({31'h0, er}, 32'h1);
        // Clock enable low freezes everything, the device clock included
        CE <= 1'b0;
        @(posedge CLK);
        ck = INPUT_CLOCK;
        repeat (3) @(posedge CLK);
        chk({31'h0, INPUT_CLOCK}, {31'h0, ck});
        CE <= 1'b1;
        // Reset in mid-run brings back default straps and active-low wait
        RST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        settle;
        chk({25'h0, u_dev.straps}, 32'h0c);
        run('{1'b0, 2'b11, 19'h40020, 16'h0, 16'hffff});
        chk(rd, 32'hbeef);
        // Software device reset re-latches new straps, wait now active high
        apb(1'b1, pchbp_pkg::PCHBP_OFS_CTRL, 32'h10);
        @(posedge CLK);
        chk({31'h0, DEVICE_RESET_N}, 32'h0);
        apb(1'b1, pchbp_pkg::PCHBP_OFS_STRAP, 32'h20);
        settle;
        chk({25'h0, u_dev.straps}, 32'h2c);
        run('{1'b0, 2'b11, 19'h40010, 16'h0, 16'hffff});
        chk(rd, 32'h9934);
        wrap_up;
    end
endmodule
`default_nettype wire
